// file: hdl/agp_regs.vh
// Purpose: Register map, field layout and reset values for the gain-control
//          pin override block.
// Assumes: Avalon-MM word addressing, one 8-bit register per 32-bit word.
// Notes:   Byte address is four times the register index.
`ifndef AGP_REGS_VH
`define AGP_REGS_VH
// Register indices
`define AGP_IDX_OVERRIDE 9'h1B0
`define AGP_IDX_DIRECTION 9'h1B1
`define AGP_IDX_DRIVE 9'h1B2
`define AGP_IDX_OUT_RB 9'h1B3
`define AGP_IDX_IN_RB 9'h1B4
`define AGP_IDX_FLAG0_SEL 9'h19B
`define AGP_IDX_FLAG1_SEL 9'h19C
`define AGP_IDX_FLAG_EN 9'h19E
// Field layout
`define AGP_PIN_MSB 3
`define AGP_SEL_MSB 2
`define AGP_EN_FLAG0 0
`define AGP_EN_FLAG1 1
`define AGP_EN_OR 4
// Flag select codes
`define AGP_SEL_RESET 3'h0
`define AGP_SEL_PK0 3'h4
`define AGP_SEL_PK1 3'h5
`define AGP_SEL_LOW 3'h6
// Reset value of all control registers
`define AGP_RST_VAL 8'h00
// Unmapped read answer
`define AGP_UNMAPPED 32'h00000000
`endif

// file: hdl/agp_flag_mux.v
// Purpose: Normal-function flag source for one gain-control pin.
// Assumes: Flag inputs are synchronous to mclk.
// Notes:   Output is registered; forced low when the enable is clear.
`timescale 1ns/1ps
`include "agp_regs.vh"
module agp_flag_mux (
   input wire mclk,
   input wire rst_n,
   input wire [`AGP_SEL_MSB:0] flag_sel,
   input wire flag_en,
   input wire or_en,
   input wire conv_reset,
   input wire peak_hi0,
   input wire peak_hi1,
   input wire peak_low,
   output reg flag_out_r
);
   reg pick; // Selected flag
   reg flag_nxt; // Next flag output

   // Choose flag, optionally OR with converter reset pulse
   always @* begin
      case (flag_sel)
         `AGP_SEL_RESET: pick = conv_reset;
         `AGP_SEL_PK0: pick = peak_hi0;
         `AGP_SEL_PK1: pick = peak_hi1;
         `AGP_SEL_LOW: pick = peak_low;
         default: pick = 1'b0;
      endcase
      if (!flag_en) begin
         flag_nxt = 1'b0;
      end else begin
         flag_nxt = pick | (or_en & conv_reset);
      end
   end

   // Output register
   always @(posedge mclk) begin
      if (!rst_n) begin
         flag_out_r <= 1'b0;
      end else begin
         flag_out_r <= flag_nxt;
      end
   end
endmodule // agp_flag_mux

// file: hdl/agp_gpio_override.v
// Purpose: GPIO override for four gain-control pins over Avalon-MM.
// Assumes: Pins are two-way; pin inputs are asynchronous to mclk.
// Notes:   Answers every access in one cycle after the request.
// Operation
// - Override bit makes pin a GPIO, top priority
// - Bits 0..3 map pins 1..4; 7:4 reserved
// - Direction one drives output, zero is input
// - Direction only matters on overridden pins
// - Overridden output drives its drive-value bit
// - Output readback shows overridden output bits
// - Input readback shows sampled overridden pin inputs
// - Override, direction, drive value reset zero
// - Pins 3,4 carry selected flag, ORed with converter reset when enabled, or low
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`include "agp_regs.vh"
module agp_gpio_override #(
   parameter NPINS = 4
) (
   input wire mclk,
   input wire rst_n,
   input wire [8:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire [NPINS-1:0] gain_ctrl_pin_in,
   output reg [NPINS-1:0] gain_ctrl_pin_out,
   output reg [NPINS-1:0] gain_ctrl_pin_oe,
   input wire [NPINS-1:0] func_out,
   input wire [NPINS-1:0] func_oe,
   input wire conv_reset,
   input wire peak_hi0,
   input wire peak_hi1,
   input wire peak_low
);
   reg [7:0] override_r; // Override select
   reg [7:0] direction_r; // Direction select
   reg [7:0] drive_r; // Drive value
   reg [7:0] flag0_sel_r; // Flag source for pin 3
   reg [7:0] flag1_sel_r; // Flag source for pin 4
   reg [7:0] flag_en_r; // Flag enables
   reg [NPINS-1:0] pin_meta_r; // First sync stage
   reg [NPINS-1:0] pin_sync_r; // Second sync stage
   reg [NPINS-1:0] in_rb_r; // Sampled input readback
   reg [NPINS-1:0] out_rb_r; // Driven output readback
   reg ack_r; // Answer given this cycle
   wire req; // Access pending
   wire wr_ok; // Write takes effect
   wire flag0_pin; // Normal function on pin 3
   wire flag1_pin; // Normal function on pin 4
   reg [NPINS-1:0] norm_out; // Normal-function data
   reg [NPINS-1:0] pin_out_nxt; // Next pin data
   reg [NPINS-1:0] pin_oe_nxt; // Next pin enable
   reg [31:0] rdata_nxt; // Read mux
   integer i;

   // One wait cycle, then the answer
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack_r;
   assign wr_ok = avs_write & ack_r & avs_byteenable[0];

   // Handshake tracker
   always @(posedge mclk) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end

   // Control register writes
   always @(posedge mclk) begin
      if (!rst_n) begin
         override_r <= `AGP_RST_VAL;
         direction_r <= `AGP_RST_VAL;
         drive_r <= `AGP_RST_VAL;
         flag0_sel_r <= `AGP_RST_VAL;
         flag1_sel_r <= `AGP_RST_VAL;
         flag_en_r <= `AGP_RST_VAL;
      end else if (wr_ok) begin
         // Readback indices fall to default and are ignored
         case (avs_address)
            `AGP_IDX_OVERRIDE: override_r <= avs_writedata[7:0];
            `AGP_IDX_DIRECTION: direction_r <= avs_writedata[7:0];
            `AGP_IDX_DRIVE: drive_r <= avs_writedata[7:0];
            `AGP_IDX_FLAG0_SEL: flag0_sel_r <= avs_writedata[7:0];
            `AGP_IDX_FLAG1_SEL: flag1_sel_r <= avs_writedata[7:0];
            `AGP_IDX_FLAG_EN: flag_en_r <= avs_writedata[7:0];
            default: ;
         endcase
      end
   end

   // Normal-function flag sources for pins 3 and 4
   agp_flag_mux u_flag0 (
      .mclk(mclk),
      .rst_n(rst_n),
      .flag_sel(flag0_sel_r[`AGP_SEL_MSB:0]),
      .flag_en(flag_en_r[`AGP_EN_FLAG0]),
      .or_en(flag_en_r[`AGP_EN_OR]),
      .conv_reset(conv_reset),
      .peak_hi0(peak_hi0),
      .peak_hi1(peak_hi1),
      .peak_low(peak_low),
      .flag_out_r(flag0_pin)
   );
   agp_flag_mux u_flag1 (
      .mclk(mclk),
      .rst_n(rst_n),
      .flag_sel(flag1_sel_r[`AGP_SEL_MSB:0]),
      .flag_en(flag_en_r[`AGP_EN_FLAG1]),
      .or_en(flag_en_r[`AGP_EN_OR]),
      .conv_reset(conv_reset),
      .peak_hi0(peak_hi0),
      .peak_hi1(peak_hi1),
      .peak_low(peak_low),
      .flag_out_r(flag1_pin)
   );

   // Pin steering: override first, then normal function
   always @* begin
      norm_out = func_out;
      norm_out[2] = flag0_pin;
      norm_out[3] = flag1_pin;
      for (i = 0; i < NPINS; i = i + 1) begin
         if (override_r[i]) begin
            pin_oe_nxt[i] = direction_r[i];
            pin_out_nxt[i] = direction_r[i] & drive_r[i];
         end else begin
            pin_oe_nxt[i] = (i >= 2) ? 1'b1 : func_oe[i];
            pin_out_nxt[i] = norm_out[i];
         end
      end
   end

   // Pin drivers and readback capture
   always @(posedge mclk) begin
      if (!rst_n) begin
         gain_ctrl_pin_out <= {NPINS{1'b0}};
         gain_ctrl_pin_oe <= {NPINS{1'b0}};
         pin_meta_r <= {NPINS{1'b0}};
         pin_sync_r <= {NPINS{1'b0}};
         in_rb_r <= {NPINS{1'b0}};
         out_rb_r <= {NPINS{1'b0}};
      end else begin
         gain_ctrl_pin_out <= pin_out_nxt;
         gain_ctrl_pin_oe <= pin_oe_nxt;
         pin_meta_r <= gain_ctrl_pin_in;
         pin_sync_r <= pin_meta_r;
         // Only pins overridden as outputs show in output readback
         out_rb_r <= pin_out_nxt & override_r[NPINS-1:0]
            & direction_r[NPINS-1:0];
         // Only pins overridden as inputs show in input readback
         in_rb_r <= pin_sync_r & override_r[NPINS-1:0]
            & ~direction_r[NPINS-1:0];
      end
   end

   // Read mux, bits above each register zero; control bits 7:4 read as written
   always @* begin
      rdata_nxt = `AGP_UNMAPPED;
      case (avs_address)
         `AGP_IDX_OVERRIDE: rdata_nxt[7:0] = override_r;
         `AGP_IDX_DIRECTION: rdata_nxt[7:0] = direction_r;
         `AGP_IDX_DRIVE: rdata_nxt[7:0] = drive_r;
         `AGP_IDX_OUT_RB: rdata_nxt[NPINS-1:0] = out_rb_r;
         `AGP_IDX_IN_RB: rdata_nxt[NPINS-1:0] = in_rb_r;
         `AGP_IDX_FLAG0_SEL: rdata_nxt[7:0] = flag0_sel_r;
         `AGP_IDX_FLAG1_SEL: rdata_nxt[7:0] = flag1_sel_r;
         `AGP_IDX_FLAG_EN: rdata_nxt[7:0] = flag_en_r;
         default: rdata_nxt = `AGP_UNMAPPED;
      endcase
   end

   // Read data register, no side effects
   always @(posedge mclk) begin
      if (!rst_n) begin
         avs_readdata <= `AGP_UNMAPPED;
      end else if (avs_read & ~ack_r) begin
         avs_readdata <= rdata_nxt;
      end
   end
endmodule // agp_gpio_override

// file: sim/agp_gpio_override_monitor.sv
// Purpose: Port checker for the pin override block
// Assumes: One clock, synchronous active-low reset
// Notes: Shadows override, direction and drive registers from accepted writes
`timescale 1ns/1ps
module agp_gpio_override_monitor #(
   parameter NPINS = 4
) (
   input wire mclk,
   input wire rst_n,
   input wire [8:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire [NPINS-1:0] gain_ctrl_pin_oe,
   input wire [NPINS-1:0] gain_ctrl_pin_out,
   input wire [NPINS-1:0] func_oe
);
   reg [NPINS-1:0] ovr_r, dir_r, val_r; // Shadow registers
   reg live_r; // High from the first edge after reset
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Shadow updates on the edge that accepts a write
   always @(posedge mclk) begin
      if (!rst_n) begin
         {ovr_r, dir_r, val_r, live_r} <= '0;
      end else begin
         live_r <= 1'h1;
         if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
            if (avs_address == 9'h1B0) ovr_r <= avs_writedata[3:0];
            if (avs_address == 9'h1B1) dir_r <= avs_writedata[3:0];
            if (avs_address == 9'h1B2) val_r <= avs_writedata[3:0];
         end
      end
   end
   AST_OVR_OE: assert property (
      live_r |-> (gain_ctrl_pin_oe & $past(ovr_r)) == $past(ovr_r & dir_r))
      else $error("Overridden pin enable wrong");
   AST_OVR_OUT: assert property (
      live_r |-> (gain_ctrl_pin_out & $past(ovr_r)) ==
      $past(ovr_r & dir_r & val_r)) else $error("Overridden pin level wrong");
   AST_FUNC_OE: assert property (
      live_r |-> (gain_ctrl_pin_oe[1:0] & ~$past(ovr_r[1:0])) ==
      $past(func_oe[1:0] & ~ovr_r[1:0])) else $error("Normal enable lost");
   AST_FLAG_DRV: assert property (
      live_r |-> (gain_ctrl_pin_oe[3:2] | $past(ovr_r[3:2])) == 2'h3)
      else $error("Flag pin not driven");
   AST_RST_IDLE: assert property (disable iff (1'h0)
      !rst_n |=> gain_ctrl_pin_out == 0 && gain_ctrl_pin_oe[1:0] == 0)
      else $error("Pins active in reset");
   AST_RD_RSVD: assert property (
      avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 0)
      else $error("Upper read bits set");
   AST_WAIT_ONE: assert property (
      $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("Wait state count wrong");
   AST_UNMAP: assert property (
      avs_read && !avs_waitrequest && !(avs_address inside {[9'h1B0:9'h1B4],
      9'h19B, 9'h19C, 9'h19E}) |-> avs_readdata == 0) else $error("Unmapped");
endmodule // agp_gpio_override_monitor

// file: sim/agp_board_model.sv
// Purpose: Board logic on the gain-control pins
// Assumes: Board drives a pin only while the device releases it
// Notes: Resolves each pin level from both parties
`timescale 1ns/1ps
module agp_board_model (
   input wire [3:0] pin_oe,
   input wire [3:0] pin_out,
   input wire [3:0] board_lvl,
   output wire [3:0] pin_lvl
);
   // Device level where it drives, board level elsewhere
   assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & board_lvl);
endmodule // agp_board_model

// file: sim/agp_gpio_override_tb.sv
// Purpose: Self-checking bench for the pin override block
// Assumes: Avalon-MM master tasks, board model on the pins
// Notes: Expected values follow the register map
`timescale 1ns/1ps
module agp_gpio_override_tb;
   reg mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0;
   reg [8:0] avs_address = 0;
   reg [31:0] avs_writedata = 0, q;
   reg [3:0] avs_byteenable = 0, func_out = 0, func_oe = 0, board_lvl = 0;
   reg conv_reset = 0, peak_hi0 = 0, peak_hi1 = 0, peak_low = 0;
   wire [31:0] avs_readdata;
   wire avs_waitrequest;
   wire [3:0] pin_lvl, gain_ctrl_pin_out, gain_ctrl_pin_oe;
   integer miscompares = 0, n_compared = 0, cyc = 0, i;
   agp_gpio_override u_dut (.mclk(mclk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .gain_ctrl_pin_in(pin_lvl),
      .gain_ctrl_pin_out(gain_ctrl_pin_out),
      .gain_ctrl_pin_oe(gain_ctrl_pin_oe), .func_out(func_out),
      .func_oe(func_oe), .conv_reset(conv_reset), .peak_hi0(peak_hi0),
      .peak_hi1(peak_hi1), .peak_low(peak_low));
   agp_board_model u_board (.pin_oe(gain_ctrl_pin_oe),
      .pin_out(gain_ctrl_pin_out), .board_lvl(board_lvl), .pin_lvl(pin_lvl));
   always #10 mclk = ~mclk;
   // Hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares = miscompares + 1;
         end_sim;
      end
   end
   task end_sim;
      begin
         if (miscompares == 0 && n_compared > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task chk(input string n, input [31:0] s, input [31:0] e);
      begin
         n_compared = n_compared + 1;
         if (s !== e) begin
            $display("MISMATCH %s exp %h seen %h", n, e, s);
            miscompares = miscompares + 1;
         end
      end
   endtask
   // One bus access; held until the edge that samples waitrequest low
   // Sampling right after the edge still sees the pre-edge values
   task acc(input rw, input [8:0] a, input [7:0] d, input [3:0] be);
      begin
         @(posedge mclk);
         avs_address <= a;
         avs_writedata <= {24'h000000, d};
         avs_byteenable <= be;
         avs_read <= rw;
         avs_write <= !rw;
         @(posedge mclk);
         while (avs_waitrequest !== 1'h0) @(posedge mclk);
         q = avs_readdata;
         avs_read <= 0;
         avs_write <= 0;
      end
   endtask
   task rd(input string n, input [8:0] a, input [31:0] e);
      begin
         acc(1, a, 8'h00, 4'hF);
         chk(n, q, e);
      end
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1;
      for (i = 0; i < 5; i = i + 1)
         rd("reset value", 9'h1B0 + i[8:0], 0);
      board_lvl <= 4'h5;
      acc(0, 9'h1B0, 8'h0F, 4'hF);
      acc(0, 9'h1B1, 8'h03, 4'hF);
      acc(0, 9'h1B2, 8'h0A, 4'hF);
      repeat (4) @(negedge mclk);
      chk("pin enable", gain_ctrl_pin_oe, 3);
      chk("pin level", gain_ctrl_pin_out, 2);
      rd("out readback", 9'h1B3, 2);
      rd("in readback", 9'h1B4, 4);
      rd("direction", 9'h1B1, 3);
      acc(0, 9'h1B3, 8'hFF, 4'hF);
      acc(0, 9'h1B0, 8'h00, 4'h0);
      rd("readback kept", 9'h1B3, 2);
      rd("override kept", 9'h1B0, 15);
      rd("unmapped", 9'h000, 0);
      func_oe <= 4'h1;
      func_out <= 4'h1;
      board_lvl <= 4'h8;
      acc(0, 9'h1B0, 8'h0E, 4'hF);
      repeat (4) @(negedge mclk);
      chk("normal pin", {gain_ctrl_pin_oe[0], gain_ctrl_pin_out[0]}, 3);
      rd("in changed", 9'h1B4, 8);
      acc(0, 9'h1B0, 8'h00, 4'hF);
      acc(0, 9'h19E, 8'h01, 4'hF);
      conv_reset <= 1;
      peak_hi1 <= 1;
      // Codes 0, 4, 5, 6 select reset, peak 0, peak 1, low
      for (i = 0; i < 4; i = i + 1) begin
         acc(0, 9'h19B, i == 0 ? 8'h00 : 8'h03 + i[7:0], 4'hF);
         repeat (4) @(negedge mclk);
         chk("flag pin", {gain_ctrl_pin_oe[2], gain_ctrl_pin_out[2]},
            {1'h1, ~i[0]});
      end
      // Pin 4 on peak 0 (low) merged with the converter reset pulse
      acc(0, 9'h19C, 8'h04, 4'hF);
      acc(0, 9'h19E, 8'h12, 4'hF);
      repeat (4) @(negedge mclk);
      chk("flag or", gain_ctrl_pin_out[3:2], 2);
      acc(0, 9'h19E, 8'h00, 4'hF);
      repeat (4) @(negedge mclk);
      chk("flag low", gain_ctrl_pin_out[3:2], 0);
      // Reset in mid-run clears the control registers again
      @(posedge mclk);
      rst_n <= 0;
      repeat (2) @(posedge mclk);
      rst_n <= 1;
      for (i = 0; i < 5; i = i + 1)
         rd("reset again", 9'h1B0 + i[8:0], 0);
      end_sim;
   end
endmodule // agp_gpio_override_tb
bind agp_gpio_override agp_gpio_override_monitor #(.NPINS(NPINS)) u_mon (
   .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .gain_ctrl_pin_oe(gain_ctrl_pin_oe),
   .gain_ctrl_pin_out(gain_ctrl_pin_out), .func_oe(func_oe));
